// ===== band_search.sv
// oscillator and sub-band autoselect engine
`timescale 1ns/10ps
module band_search (
	input  wire logic      ref_clk,
	input  wire logic      rst_b,
	band_search_if.search  bus
);
	typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_CHECK, S_DONE, S_FAIL} search_e;
	search_e    state_reg, state_next;
	logic [1:0] osc_reg, osc_next;
	logic [2:0] sub_reg, sub_next;
	logic [4:0] wait_reg, wait_next;

	// step sub-band up or down on an out-of-window reading, fail past the last band of the last oscillator or the first band of the first
	always_comb begin
		state_next = state_reg;
		osc_next   = osc_reg;
		sub_next   = sub_reg;
		wait_next  = wait_reg;
		if (bus.abort) begin
			state_next = S_IDLE;
		end else if (bus.start) begin
			state_next = S_SETTLE;
			osc_next   = bus.start_osc;
			sub_next   = bus.start_sub;
			wait_next  = 5'(synth_cfg_pkg::SETTLE_CYC);
		end else begin
			case (state_reg)
				S_SETTLE: begin
					wait_next = wait_reg - 5'h01;
					if (wait_reg == 5'h01) begin
						state_next = S_CHECK;
					end
				end
				S_CHECK: begin
					wait_next = 5'(synth_cfg_pkg::SETTLE_CYC);
					state_next = S_SETTLE;
					if (bus.adc_code == synth_cfg_pkg::ADC_HIGH) begin
						if (sub_reg != 3'h7) begin
							sub_next = sub_reg + 3'h1;
						end else if (osc_reg != 2'h3) begin
							osc_next = osc_reg + 2'h1;
							sub_next = 3'h0;
						end else begin
							state_next = S_FAIL;
						end
					end else if (bus.adc_code == synth_cfg_pkg::ADC_LOW) begin
						if (sub_reg != 3'h0) begin
							sub_next = sub_reg - 3'h1;
						end else if (osc_reg != 2'h0) begin
							osc_next = osc_reg - 2'h1;
							sub_next = 3'h7;
						end else begin
							state_next = S_FAIL;
						end
					end else begin
						state_next = S_DONE;
					end
				end
				S_IDLE, S_DONE, S_FAIL: begin
					state_next = state_reg;
				end
				default: begin
					state_next = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_IDLE;
			osc_reg   <= 2'h0;
			sub_reg   <= 3'h0;
			wait_reg  <= 5'h00;
		end else begin
			state_reg <= state_next;
			osc_reg   <= osc_next;
			sub_reg   <= sub_next;
			wait_reg  <= wait_next;
		end
	end

	// status toward the register bank
	assign bus.osc     = osc_reg;
	assign bus.sub     = sub_reg;
	assign bus.reading = (state_reg == S_CHECK);
	assign bus.idle    = (state_reg == S_IDLE) || (state_reg == S_DONE) || (state_reg == S_FAIL);
	assign bus.ok      = (state_reg == S_DONE);

	a_search_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
		bus.start && !bus.abort |=> !bus.idle && osc_reg == $past(bus.start_osc))
		else $error("search did not start from written oscillator");
endmodule // band_search

// ===== band_search_if.sv
// carrier between the register bank and the band search engine
`timescale 1ns/10ps
interface band_search_if;
	logic       start;
	logic       abort;
	logic [1:0] start_osc;
	logic [2:0] start_sub;
	logic [2:0] adc_code;
	logic [1:0] osc;
	logic [2:0] sub;
	logic       reading;
	logic       idle;
	logic       ok;
	modport ctrl (output start, output abort, output start_osc, output start_sub,
		output adc_code, input osc, input sub, input reading, input idle, input ok);
	modport search (input start, input abort, input start_osc, input start_sub,
		input adc_code, output osc, output sub, output reading, output idle, output ok);
endinterface

// ===== prebias_timer.sv
// one-shot prebias window with two selectable lengths
`timescale 1ns/10ps
module prebias_timer #(
	parameter int SHORT_CYC = 28,
	parameter int LONG_CYC  = 65
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic enable,
	input  wire logic trigger,
	input  wire logic long_sel,
	output logic      active
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// load on trigger, count down, disable kills the window
	always_comb begin
		cnt_next = cnt_reg;
		if (!enable) begin
			cnt_next = 8'h00;
		end else if (trigger && cnt_reg == 8'h00) begin
			cnt_next = long_sel ? 8'(LONG_CYC) : 8'(SHORT_CYC);
		end else if (cnt_reg != 8'h00) begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign active = (cnt_reg != 8'h00);

	a_prebias_off: assert property (@(posedge ref_clk) disable iff (!rst_b) !enable |=> !active)
		else $error("prebias active while disabled");
	a_prebias_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
		enable && trigger && !active && !long_sel |=> cnt_reg == 8'(SHORT_CYC))
		else $error("prebias short window length wrong");
endmodule // prebias_timer

// ===== synth_cfg_pkg.sv
// constants for the tuner synthesizer and test configuration registers
package synth_cfg_pkg;
	// register addresses on the serial control port
	localparam logic [7:0] TEST_CONFIG_ADDR  = 8'h00;
	localparam logic [7:0] SYNTH_PUMP_ADDR   = 8'h01;
	localparam logic [7:0] OSC_SELECT_ADDR   = 8'h02;
	// values after reset
	localparam logic [7:0] TEST_CONFIG_RST   = 8'h10;
	localparam logic [7:0] SYNTH_PUMP_RST    = 8'hF1;
	localparam logic [7:0] OSC_SELECT_RST    = 8'hD8;
	// test_config fields
	localparam int TRIM_MSB        = 7;
	localparam int TRIM_LSB        = 5;
	localparam int TRIM_SRC_BIT    = 4;
	localparam int MIXER_OFF_BIT   = 3;
	localparam int DIAG_MSB        = 2;
	localparam int DIAG_LSB        = 0;
	// synth_pump_config fields
	localparam int PUMP_CUR_MSB    = 7;
	localparam int PUMP_CUR_LSB    = 6;
	localparam int PUMP_AUTO_BIT   = 5;
	localparam int PREBIAS_EN_BIT  = 4;
	localparam int REF_PB_TIME_BIT = 3;
	localparam int OSC_PB_TIME_BIT = 2;
	localparam int PUMP_ON_BIT     = 1;
	localparam int AUTO_BAND_BIT   = 0;
	// oscillator_select fields
	localparam int OSC_MSB         = 7;
	localparam int OSC_LSB         = 6;
	localparam int SUB_MSB         = 5;
	localparam int SUB_LSB         = 3;
	localparam int ADC_HOLD_BIT    = 2;
	localparam int ADC_READ_BIT    = 1;
	localparam int RAMP_CUR_BIT    = 0;
	// status byte-1 fields
	localparam int STAT_PUMP_MSB   = 4;
	localparam int STAT_PUMP_LSB   = 3;
	localparam int STAT_OK_BIT     = 1;
	localparam int STAT_IDLE_BIT   = 0;
	// diagnostic codes
	localparam logic [2:0] DIAG_NORMAL  = 3'h0;
	localparam logic [2:0] DIAG_SOURCE  = 3'h1;
	localparam logic [2:0] DIAG_SINK    = 3'h2;
	localparam logic [2:0] DIAG_HIZ     = 3'h3;
	localparam logic [2:0] DIAG_DETECT  = 3'h4;
	localparam logic [2:0] DIAG_FB_DIV  = 3'h5;
	localparam logic [2:0] DIAG_REF_DIV = 3'h6;
	localparam logic [2:0] DIAG_LO      = 3'h7;
	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int REF_PB_SHORT_NS = 280;
	localparam int REF_PB_LONG_NS  = 650;
	localparam int OSC_PB_SHORT_NS = 500;
	localparam int OSC_PB_LONG_NS  = 1000;
	localparam int REF_PB_SHORT_CYC = (REF_PB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_PB_LONG_CYC  = (REF_PB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_PB_SHORT_CYC = (OSC_PB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_PB_LONG_CYC  = (OSC_PB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC       = 16;
	// tuning-voltage adc window edges
	localparam logic [2:0] ADC_LOW  = 3'h0;
	localparam logic [2:0] ADC_HIGH = 3'h7;
endpackage

// ===== tb_top.sv
// self-checking bench for the tuner configuration register bank
`timescale 1ns/10ps
module tb_top;
	logic       ref_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       wr_en = 1'b0;
	logic [7:0] wr_addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [2:0] factory_trim = 3'h6;
	logic [2:0] tune_adc_code = 3'h3;
	logic       ref_div_pulse = 1'b0;
	logic       fb_div_pulse = 1'b0;
	logic       fb_div_out = 1'b1;
	logic       ref_div_out = 1'b0;
	logic       lo_out = 1'b1;
	logic [2:0] trim;
	logic       src, mix, f_src, f_snk, f_hiz, pdet, tpin, on_sel, pb_ref, pb_osc;
	logic [1:0] pump, osc;
	logic [2:0] sub;
	logic       hold, rd_en, ramp;
	logic [7:0] stat;
	int         errors = 0;
	int         compares = 0;
	int         cycles = 0;
	localparam int POWER_UP_CYC = 10000; // 100us of 10ns cycles

	tuner_synth_test_config_regs tuner_synth_test_config_regs_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .factory_trim(factory_trim), .tune_adc_code(tune_adc_code),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
		.fb_div_out(fb_div_out), .ref_div_out(ref_div_out), .lo_out(lo_out),
		.filter_center_trim(trim), .filter_trim_source(src), .mixer_off(mix),
		.pump_force_source(f_src), .pump_force_sink(f_snk), .pump_force_hiz(f_hiz),
		.power_detect_pin(pdet), .test_pin(tpin), .pump_current_sel(pump),
		.pump_on_time_sel(on_sel), .prebias_ref_on(pb_ref), .prebias_osc_on(pb_osc),
		.oscillator_sel(osc), .sub_band_sel(sub), .tune_adc_hold(hold),
		.tune_adc_read_en(rd_en), .auto_select_ramp_current(ramp), .status_byte1(stat));

	// free-running 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out;
		end
	end

	task automatic close_out;
		$display("checks %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one completed serial write, one cycle of wr_en
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(posedge ref_clk);
		#1;
		wr_en = 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// power-up wait, then every register written once before any scenario
	task automatic power_up_scn;
		repeat (POWER_UP_CYC) @(posedge ref_clk);
		#1;
		chk("reset auto pump", 8'(pump), 8'h01);
		wr(synth_cfg_pkg::TEST_CONFIG_ADDR, synth_cfg_pkg::TEST_CONFIG_RST);
		wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, synth_cfg_pkg::SYNTH_PUMP_RST);
		wr(synth_cfg_pkg::OSC_SELECT_ADDR, synth_cfg_pkg::OSC_SELECT_RST);
		settle;
		chk("power-up source", 8'(src), 8'h01);
	endtask

	// every trim and diagnostic code, then factory source and an unmapped write
	task automatic test_scn;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			fb_div_out = (c == 3'h5);
			ref_div_out = (c == 3'h6);
			lo_out = (c == 3'h7);
			wr(synth_cfg_pkg::TEST_CONFIG_ADDR, {c, 1'b0, c[0], c});
			settle;
			chk("trim", 8'(trim), 8'(c));
			chk("trim source", 8'(src), 8'h00);
			chk("mixer off", 8'(mix), 8'(c[0]));
			chk("force source", 8'(f_src), 8'(c == 3'h1));
			chk("force sink", 8'(f_snk), 8'(c == 3'h2));
			chk("force hiz", 8'(f_hiz), 8'(c == 3'h3));
			chk("power detect", 8'(pdet), 8'(c == 3'h4));
			chk("test pin", 8'(tpin), 8'(c >= 3'h5));
		end
		wr(synth_cfg_pkg::TEST_CONFIG_ADDR, 8'hF0);
		wr(8'h05, 8'h00);
		settle;
		chk("factory trim", 8'(trim), 8'h06);
	endtask

	// manual pump currents, on-time select, then automatic pump choice
	task automatic pump_scn;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, {c, 4'h0, c[0], 1'b0});
			settle;
			chk("pump", 8'(pump), 8'(c));
			chk("status pump", 8'(stat[4:3]), 8'(c));
			chk("on time", 8'(on_sel), 8'(c[0]));
		end
		tune_adc_code = 3'h5;
		wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, 8'h20);
		settle;
		chk("auto pump", 8'(pump), 8'h02);
		chk("status auto pump", 8'(stat[4:3]), 8'h02);
	endtask

	// manual oscillator register fields while autoselect is off
	task automatic osc_scn(input logic [7:0] d);
		wr(synth_cfg_pkg::OSC_SELECT_ADDR, d);
		settle;
		chk("osc", 8'(osc), 8'(d[7:6]));
		chk("sub band", 8'(sub), 8'(d[5:3]));
		chk("adc hold", 8'(hold), 8'(d[2]));
		chk("adc read", 8'(rd_en), 8'(d[1]));
		chk("ramp", 8'(ramp), 8'(d[0]));
	endtask

	// prebias window length in cycles after one divider pulse
	task automatic pb_scn(input logic en, input logic use_ref, input logic lng, input int exp);
		int n;
		n = 0;
		wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, {3'h0, en, lng, lng, 2'h0});
		settle;
		if (use_ref) ref_div_pulse = 1'b1;
		else fb_div_pulse = 1'b1;
		@(posedge ref_clk);
		#1;
		ref_div_pulse = 1'b0;
		fb_div_pulse = 1'b0;
		for (int k = 0; k < 200; k++) begin
			if ((use_ref ? pb_ref : pb_osc) === 1'b1) n++;
			else if (n > 0) break;
			@(posedge ref_clk);
			#1;
		end
		chk("prebias length", 8'(n), 8'(exp));
	endtask

	task automatic wait_idle;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("search active", 8'(stat[0]), 8'h00);
		for (int k = 0; k < 100 && stat[0] !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("search idle", 8'(stat[0]), 8'h01);
	endtask

	// autoselect success from a seed, a failing search, then manual fallback
	task automatic auto_scn;
		tune_adc_code = 3'h3;
		wr(synth_cfg_pkg::OSC_SELECT_ADDR, 8'h98);
		wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, 8'h01);
		wait_idle;
		chk("search ok", 8'(stat[1]), 8'h01);
		chk("seed osc", 8'(osc), 8'h02);
		chk("seed sub", 8'(sub), 8'h03);
		tune_adc_code = 3'h7;
		wr(synth_cfg_pkg::OSC_SELECT_ADDR, 8'hF8);
		wait_idle;
		chk("search failed", 8'(stat[1]), 8'h00);
		wr(synth_cfg_pkg::SYNTH_PUMP_ADDR, 8'h00);
		settle;
		chk("manual osc", 8'(osc), 8'h03);
		chk("manual sub", 8'(sub), 8'h07);
	endtask

	// reset, then each scenario in turn
	initial begin
		repeat (20) @(posedge ref_clk);
		#1;
		chk("reset status", stat, 8'h19);
		chk("reset source", 8'(src), 8'h01);
		rst_b = 1'b1;
		power_up_scn;
		test_scn;
		pump_scn;
		osc_scn(8'hAE);
		osc_scn(8'h51);
		pb_scn(1'b1, 1'b1, 1'b0, synth_cfg_pkg::REF_PB_SHORT_CYC);
		pb_scn(1'b1, 1'b1, 1'b1, synth_cfg_pkg::REF_PB_LONG_CYC);
		pb_scn(1'b1, 1'b0, 1'b0, synth_cfg_pkg::OSC_PB_SHORT_CYC);
		pb_scn(1'b1, 1'b0, 1'b1, synth_cfg_pkg::OSC_PB_LONG_CYC);
		pb_scn(1'b0, 1'b1, 1'b0, 0);
		auto_scn;
		close_out;
	end
endmodule // tb_top

// ===== tuner_synth_test_config_regs.sv
// write-only test, synthesizer and oscillator configuration registers of the tuner
// How it works
// - trim field bits 7:5 scale filter center from 0.75 to 1.32 of 571kHz
// - test bit 4 picks factory trim when 1, manual trim field when 0
// - test bit 3 set disables the quadrature mixers for filter tuning
// - diagnostic 000 normal; 001 source, 010 sink, 011 pump high impedance
// - code 100 routes detector rms; 101/110/111 put dividers or LO on test pin
// - synth bits 7:6 pick pump current 1.5, 2, 2.5 or 3 mA
// - synth bit 5 clear means manual pump current, set means chosen from adc
// - synth bit 4 enables the charge-pump prebias function
// - synth bit 3 sets reference prebias on-time, 280ns or 650ns
// - synth bit 2 sets oscillator prebias on-time, 500ns or 1000ns
// - synth bit 1 sets pump on-time, 2.5ns or 5ns
// - synth bit 0 enables autoselect; clear uses manual oscillator and sub-band
// - oscillator bits 7:6 pick oscillator manually and seed autoselect
// - oscillator bits 5:3 pick sub-band manually and seed autoselect
// - oscillator bit 2 latches tuning adc while autoselect is off
// - oscillator bit 1 enables tuning adc read while autoselect is off
// - oscillator bit 0 picks 1 or 2 microamp autoselect ramp current
// - status byte bits 4:3 show pump current in use
// - status bit 1 autoselect success, bit 0 low while autoselect active
`timescale 1ns/10ps
module tuner_synth_test_config_regs (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [2:0] factory_trim,
	input  wire logic [2:0] tune_adc_code,
	input  wire logic       ref_div_pulse,
	input  wire logic       fb_div_pulse,
	input  wire logic       fb_div_out,
	input  wire logic       ref_div_out,
	input  wire logic       lo_out,
	output logic [2:0]      filter_center_trim,
	output logic            filter_trim_source,
	output logic            mixer_off,
	output logic            pump_force_source,
	output logic            pump_force_sink,
	output logic            pump_force_hiz,
	output logic            power_detect_pin,
	output logic            test_pin,
	output logic [1:0]      pump_current_sel,
	output logic            pump_on_time_sel,
	output logic            prebias_ref_on,
	output logic            prebias_osc_on,
	output logic [1:0]      oscillator_sel,
	output logic [2:0]      sub_band_sel,
	output logic            tune_adc_hold,
	output logic            tune_adc_read_en,
	output logic            auto_select_ramp_current,
	output logic [7:0]      status_byte1
);
	logic [7:0] test_config_reg, test_config_next;
	logic [7:0] synth_pump_config_reg, synth_pump_config_next;
	logic [7:0] oscillator_select_reg, oscillator_select_next;
	logic [7:0] out_reg, out_next;
	logic [2:0] trim_reg, trim_next;
	logic [1:0] pump_reg, pump_next;
	logic [1:0] osc_reg, osc_next;
	logic [2:0] sub_reg, sub_next;
	logic       start_reg, start_next;
	logic       wr_test, wr_synth, wr_osc;
	logic       auto_band, pump_auto;
	logic [2:0] diag;

	band_search_if band_bus ();

	// address decode of completed serial writes
	assign wr_test  = wr_en && (wr_addr == synth_cfg_pkg::TEST_CONFIG_ADDR);
	assign wr_synth = wr_en && (wr_addr == synth_cfg_pkg::SYNTH_PUMP_ADDR);
	assign wr_osc   = wr_en && (wr_addr == synth_cfg_pkg::OSC_SELECT_ADDR);

	// register storage, only the addressed byte changes
	always_comb begin
		test_config_next       = wr_test  ? wr_data : test_config_reg;
		synth_pump_config_next = wr_synth ? wr_data : synth_pump_config_reg;
		oscillator_select_next = wr_osc   ? wr_data : oscillator_select_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			test_config_reg       <= synth_cfg_pkg::TEST_CONFIG_RST;
			synth_pump_config_reg <= synth_cfg_pkg::SYNTH_PUMP_RST;
			oscillator_select_reg <= synth_cfg_pkg::OSC_SELECT_RST;
		end else begin
			test_config_reg       <= test_config_next;
			synth_pump_config_reg <= synth_pump_config_next;
			oscillator_select_reg <= oscillator_select_next;
		end
	end

	assign auto_band = synth_pump_config_reg[synth_cfg_pkg::AUTO_BAND_BIT];
	assign pump_auto = synth_pump_config_reg[synth_cfg_pkg::PUMP_AUTO_BIT];
	assign diag      = test_config_reg[synth_cfg_pkg::DIAG_MSB:synth_cfg_pkg::DIAG_LSB];

	// autoselect launch on any synth or oscillator write with autoselect on
	assign start_next          = (wr_synth && wr_data[synth_cfg_pkg::AUTO_BAND_BIT])
		|| (wr_osc && auto_band);
	assign band_bus.start      = start_reg;
	assign band_bus.abort      = !auto_band;
	assign band_bus.start_osc  = oscillator_select_reg[synth_cfg_pkg::OSC_MSB:synth_cfg_pkg::OSC_LSB];
	assign band_bus.start_sub  = oscillator_select_reg[synth_cfg_pkg::SUB_MSB:synth_cfg_pkg::SUB_LSB];
	assign band_bus.adc_code   = tune_adc_code;

	band_search u_search (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.bus     (band_bus.search)
	);

	// operating values derived from the fields
	always_comb begin
		trim_next = test_config_reg[synth_cfg_pkg::TRIM_SRC_BIT] ? factory_trim
			: test_config_reg[synth_cfg_pkg::TRIM_MSB:synth_cfg_pkg::TRIM_LSB];
		pump_next = pump_auto ? tune_adc_code[2:1]
			: synth_pump_config_reg[synth_cfg_pkg::PUMP_CUR_MSB:synth_cfg_pkg::PUMP_CUR_LSB];
		osc_next  = auto_band ? band_bus.osc
			: oscillator_select_reg[synth_cfg_pkg::OSC_MSB:synth_cfg_pkg::OSC_LSB];
		sub_next  = auto_band ? band_bus.sub
			: oscillator_select_reg[synth_cfg_pkg::SUB_MSB:synth_cfg_pkg::SUB_LSB];
	end

	// diagnostic decode into registered pin controls
	always_comb begin
		out_next = 8'h00;
		out_next[0] = test_config_reg[synth_cfg_pkg::MIXER_OFF_BIT];
		case (diag)
			synth_cfg_pkg::DIAG_NORMAL:  out_next[7:1] = 7'h00;
			synth_cfg_pkg::DIAG_SOURCE:  out_next[1] = 1'b1;
			synth_cfg_pkg::DIAG_SINK:    out_next[2] = 1'b1;
			synth_cfg_pkg::DIAG_HIZ:     out_next[3] = 1'b1;
			synth_cfg_pkg::DIAG_DETECT:  out_next[4] = 1'b1;
			synth_cfg_pkg::DIAG_FB_DIV:  out_next[5] = fb_div_out;
			synth_cfg_pkg::DIAG_REF_DIV: out_next[5] = ref_div_out;
			synth_cfg_pkg::DIAG_LO:      out_next[5] = lo_out;
			default:                     out_next[7:1] = 7'h00;
		endcase
		out_next[6] = test_config_reg[synth_cfg_pkg::TRIM_SRC_BIT];
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_reg   <= 8'h40;
			trim_reg  <= 3'h0;
			pump_reg  <= 2'h3;
			osc_reg   <= 2'h3;
			sub_reg   <= 3'h3;
			start_reg <= 1'b0;
		end else begin
			out_reg   <= out_next;
			trim_reg  <= trim_next;
			pump_reg  <= pump_next;
			osc_reg   <= osc_next;
			sub_reg   <= sub_next;
			start_reg <= start_next;
		end
	end

	// prebias windows launched by divider edges
	prebias_timer #(
		.SHORT_CYC (synth_cfg_pkg::REF_PB_SHORT_CYC),
		.LONG_CYC  (synth_cfg_pkg::REF_PB_LONG_CYC)
	) u_ref_prebias (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.enable   (synth_pump_config_reg[synth_cfg_pkg::PREBIAS_EN_BIT]),
		.trigger  (ref_div_pulse),
		.long_sel (synth_pump_config_reg[synth_cfg_pkg::REF_PB_TIME_BIT]),
		.active   (prebias_ref_on)
	);

	prebias_timer #(
		.SHORT_CYC (synth_cfg_pkg::OSC_PB_SHORT_CYC),
		.LONG_CYC  (synth_cfg_pkg::OSC_PB_LONG_CYC)
	) u_osc_prebias (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.enable   (synth_pump_config_reg[synth_cfg_pkg::PREBIAS_EN_BIT]),
		.trigger  (fb_div_pulse),
		.long_sel (synth_pump_config_reg[synth_cfg_pkg::OSC_PB_TIME_BIT]),
		.active   (prebias_osc_on)
	);

	// pin level outputs
	assign filter_center_trim       = trim_reg;
	assign filter_trim_source       = out_reg[6];
	assign mixer_off                = out_reg[0];
	assign pump_force_source        = out_reg[1];
	assign pump_force_sink          = out_reg[2];
	assign pump_force_hiz           = out_reg[3];
	assign power_detect_pin         = out_reg[4];
	assign test_pin                 = out_reg[5];
	assign pump_current_sel         = pump_reg;
	assign pump_on_time_sel         = synth_pump_config_reg[synth_cfg_pkg::PUMP_ON_BIT];
	assign oscillator_sel           = osc_reg;
	assign sub_band_sel             = sub_reg;
	assign auto_select_ramp_current = oscillator_select_reg[synth_cfg_pkg::RAMP_CUR_BIT];
	// adc controls belong to the search engine while autoselect runs
	assign tune_adc_hold    = auto_band ? 1'b0
		: oscillator_select_reg[synth_cfg_pkg::ADC_HOLD_BIT];
	assign tune_adc_read_en = auto_band ? band_bus.reading
		: oscillator_select_reg[synth_cfg_pkg::ADC_READ_BIT];

	// status byte: pump current in use, search result and activity
	always_comb begin
		status_byte1 = 8'h00;
		status_byte1[synth_cfg_pkg::STAT_PUMP_MSB:synth_cfg_pkg::STAT_PUMP_LSB] = pump_reg;
		status_byte1[synth_cfg_pkg::STAT_OK_BIT]   = band_bus.ok;
		status_byte1[synth_cfg_pkg::STAT_IDLE_BIT] = band_bus.idle;
	end

	// filter trim, trim source and mixer disable
	a_trim_manual: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_test && !wr_data[4] ##1 !wr_en |=> filter_center_trim == $past(wr_data[7:5], 2))
		else $error("manual filter trim not applied");
	a_trim_factory: assert property (@(posedge ref_clk) disable iff (!rst_b)
		test_config_reg[4] |=> filter_center_trim == $past(factory_trim))
		else $error("factory trim not selected");
	a_trim_source: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_test |=> ##1 filter_trim_source == $past(wr_data[4], 2))
		else $error("trim source does not follow write");
	a_mixer_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_test |=> ##1 mixer_off == $past(wr_data[3], 2))
		else $error("mixer disable does not follow write");

	// diagnostic routing, one pin action per code other than normal
	a_diag_normal: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h0 |=> !pump_force_source && !pump_force_sink && !pump_force_hiz)
		else $error("pump forced in normal operation");
	a_diag_source: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h1 |=> pump_force_source && !pump_force_sink && !pump_force_hiz)
		else $error("pump source not forced");
	a_diag_sink: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h2 |=> pump_force_sink && !pump_force_source && !pump_force_hiz)
		else $error("pump sink not forced");
	a_diag_hiz: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h3 |=> pump_force_hiz && !pump_force_source && !pump_force_sink)
		else $error("pump not high impedance for code 3");
	a_diag_detect: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h4 |=> power_detect_pin && !test_pin && !pump_force_hiz)
		else $error("detector not routed");
	a_diag_feedback: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h5 |=> test_pin == $past(fb_div_out) && !power_detect_pin)
		else $error("feedback divider not routed to test pin");
	a_diag_reference: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h6 |=> test_pin == $past(ref_div_out) && !power_detect_pin)
		else $error("reference divider not routed to test pin");
	a_diag_lo: assert property (@(posedge ref_clk) disable iff (!rst_b)
		diag == 3'h7 |=> test_pin == $past(lo_out) && !power_detect_pin)
		else $error("oscillator not routed to test pin");

	// pump current and on-time
	a_pump_manual: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!pump_auto |=> pump_current_sel == $past(synth_pump_config_reg[7:6]))
		else $error("manual pump current not used");
	a_pump_auto: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pump_auto |=> pump_current_sel == $past(tune_adc_code[2:1]))
		else $error("auto pump current not used");
	a_on_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_synth |=> pump_on_time_sel == $past(wr_data[1]))
		else $error("pump on-time select does not follow write");

	// oscillator choice and adc controls
	a_manual_band: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!auto_band |=> oscillator_sel == $past(oscillator_select_reg[7:6])
			&& sub_band_sel == $past(oscillator_select_reg[5:3]))
		else $error("manual oscillator choice not used");
	a_auto_band: assert property (@(posedge ref_clk) disable iff (!rst_b)
		auto_band |=> oscillator_sel == $past(band_bus.osc)
			&& sub_band_sel == $past(band_bus.sub))
		else $error("search choice not used");
	a_adc_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		auto_band |-> !tune_adc_hold)
		else $error("adc hold active during autoselect");
	a_adc_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_osc && !auto_band |=> tune_adc_hold == $past(wr_data[2]))
		else $error("adc hold does not follow write");
	a_adc_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_osc && !auto_band |=> tune_adc_read_en == $past(wr_data[1]))
		else $error("adc read enable does not follow write");
	a_ramp_current: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_osc |=> auto_select_ramp_current == $past(wr_data[0]))
		else $error("ramp current select does not follow write");

	// search status and write isolation
	a_status_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		start_reg && auto_band |=> !status_byte1[0] && status_byte1[4:3] == pump_current_sel)
		else $error("status does not show active search");
	a_search_launch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_synth && wr_data[0] ##1 auto_band |=> !status_byte1[0])
		else $error("autoselect not launched by write");
	a_abort_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!auto_band |=> status_byte1[0] && !status_byte1[1])
		else $error("status not idle with autoselect off");
	a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_en && wr_addr > 8'h02 |=> test_config_reg == $past(test_config_reg)
			&& synth_pump_config_reg == $past(synth_pump_config_reg))
		else $error("unmapped write changed a register");
endmodule // tuner_synth_test_config_regs
